// ### inc/trp_pkg.sv
/*
 * Shared constants and types of the trace RAM readout port.
 * Assumes one core clock and an APB-style register access from a debug host.
 */
// Functional notes
// (R1) With capture disabled, the read-data register holds the RAM word at the read pointer.
// (R2) Each read of the read-data register bumps the pointer and starts a new RAM fetch.
// (R3) With capture enabled, a read of the read-data register returns all ones.
// (R4) A read that returns all ones leaves the read pointer unchanged.
// (R5) Software may take an all-ones word as a read error while formatting is on.
// (R6) A pointer write loads the pointer, starts a fetch, then refreshes the read data.
// (R7) Reading the pointer register returns the pointer with no side effect.
// (R8) Capture is enabled exactly when formatter_stopped is 0 and capture_enable_bit is 1.
// (R9) Software must not write the pointer register while capture is enabled.
// (R10) Pointer writes during capture are ignored.
// (R11) The pointer register holds a 10-bit pointer in bits 9:0, bits 31:10 reserved.
// (R12) The read-data register is a 32-bit read-only word from the RAM.
// (R13) The RAM depth register reports the RAM size in words as 32 bits.
// (R14) End of acquisition, by stop event or enable cleared, sets formatter_stopped to 1.
// (R15) The pointer wraps to zero after its maximum value.
// (R16) A pending fetch completes before a data read or pointer write is answered; with capture enabled the code answers them without waiting.

`default_nettype none

package trp_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int unsigned PTR_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned RAM_DEPTH = 1024;
    localparam int unsigned FIFO_DEPTH = 8;

    // ------------------------------------------------------------
    // register offsets, fields and values
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_RAM_DEPTH = 12'h004;
    localparam logic [11:0] OFS_READ_DATA = 12'h010;
    localparam logic [11:0] OFS_READ_PTR = 12'h014;
    localparam int unsigned PTR_LSB = 0;
    localparam logic [31:0] RAM_DEPTH_VAL = 32'h0000_0400;
    localparam logic [31:0] READ_ERR_WORD = 32'hFFFF_FFFF;
    localparam logic [9:0] PTR_RST = 10'h000;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic STOPPED_RST = 1'b1;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } trp_apb_req_s;

    typedef struct packed {
        logic [9:0] addr;
        logic [31:0] data;
    } trp_cap_word_s;

    typedef enum logic [2:0] {
        FETCH_IDLE = 3'b001,
        FETCH_REQ = 3'b010,
        FETCH_LOAD = 3'b100
    } trp_fetch_e;

endpackage

`default_nettype wire

// ### src/trp_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two; one clock, async active-low reset.
 */
`default_nettype none

module trp_fifo #(
    parameter int unsigned WIDTH = 42,
    parameter int unsigned DEPTH = 8
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic ready_r, ready_nxt;
    logic push, pop;

    // ------------------------------------------------------------
    // pointers and fill level
    // ------------------------------------------------------------
    always_comb begin
        push = i_in_valid && ready_r;
        pop = (cnt_r != '0) && i_out_ready;
        wr_nxt = push ? wr_r + AW'(1) : wr_r;
        rd_nxt = pop ? rd_r + AW'(1) : rd_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        ready_nxt = (cnt_nxt != (AW+1)'(DEPTH));
    end

    // state registers
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b1;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
            ready_r <= ready_nxt;
        end
    end

    // storage, no reset
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem_r[wr_r] <= i_in_data;
        end
    end

    // outputs
    assign o_in_ready = ready_r;
    assign o_out_valid = (cnt_r != '0);
    assign o_out_data = mem_r[rd_r];

    a_fifo_no_overfill: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
        cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule

`default_nettype wire

// ### src/trp_trace_ram.sv
/*
 * Single-port trace RAM, one-cycle synchronous read.
 * Assumes the caller never asserts read and write together; read wins.
 */
`default_nettype none

module trp_trace_ram (
    // clock
    input wire logic i_core_clk,
    // read port
    input wire logic i_rd_en,
    input wire logic [trp_pkg::PTR_W-1:0] i_rd_addr,
    output logic [trp_pkg::DATA_W-1:0] o_rd_data,
    // write port
    input wire logic i_wr_en,
    input wire logic [trp_pkg::PTR_W-1:0] i_wr_addr,
    input wire logic [trp_pkg::DATA_W-1:0] i_wr_data
);
    logic [trp_pkg::DATA_W-1:0] mem_r [trp_pkg::RAM_DEPTH];
    logic [trp_pkg::DATA_W-1:0] q_r;

    // one access per cycle
    always_ff @(posedge i_core_clk) begin
        if (i_rd_en) begin
            q_r <= mem_r[i_rd_addr];
        end else if (i_wr_en) begin
            mem_r[i_wr_addr] <= i_wr_data;
        end
    end

    assign o_rd_data = q_r;

endmodule

`default_nettype wire

// ### src/trp_readout.sv
/*
 * Trace RAM readout port: pointer, read-data and depth registers on APB,
 * plus the capture write path through a FIFO into the trace RAM.
 * Assumes the capture control register and stop event come from logic on
 * the same clock, and the capture words carry their own RAM address.
 */
`default_nettype none

module trp_readout (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // apb slave
    input wire trp_pkg::trp_apb_req_s i_apb,
    output logic [31:0] o_apb_prdata,
    output logic o_apb_pready,
    output logic o_apb_pslverr,
    // capture control
    input wire logic i_capture_enable_bit,
    input wire logic i_fmt_stop_event,
    output logic o_formatter_stopped,
    // capture word stream
    input wire logic i_cap_valid,
    input wire trp_pkg::trp_cap_word_s i_cap_word,
    output logic o_cap_ready
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    trp_pkg::trp_fetch_e fetch_r, fetch_nxt;
    logic [9:0] ptr_r, ptr_nxt;
    logic [31:0] data_r, data_nxt;
    logic pend_r, pend_nxt;
    logic stopped_r, stopped_nxt;
    logic en_d_r, en_d_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic cap_en, fetch_idle, acc, can_take, take;
    logic hit_data, hit_ptr, hit_depth;
    logic take_data_rd, take_ptr_wr, take_ptr_rd, take_depth_rd;
    logic [31:0] ram_q;
    logic fifo_valid, ram_wr;
    trp_pkg::trp_cap_word_s fifo_word;

    // address decode helper
    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    always_comb begin
        cap_en = !stopped_r && i_capture_enable_bit; // [R8]
        fetch_idle = (fetch_r == trp_pkg::FETCH_IDLE) && !pend_r;
        acc = i_apb.sel && i_apb.enable && !pready_r;
        hit_data = reg_hit(i_apb.addr, trp_pkg::OFS_READ_DATA);
        hit_ptr = reg_hit(i_apb.addr, trp_pkg::OFS_READ_PTR);
        hit_depth = reg_hit(i_apb.addr, trp_pkg::OFS_RAM_DEPTH);
        // wait states while a fetch is still running
        can_take = !(hit_data || hit_ptr) || cap_en || fetch_idle; // [R16]
        take = acc && can_take;
        take_data_rd = take && hit_data && !i_apb.write;
        take_ptr_wr = take && hit_ptr && i_apb.write;
        take_ptr_rd = take && hit_ptr && !i_apb.write;
        take_depth_rd = take && hit_depth && !i_apb.write;
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    always_comb begin
        pready_nxt = take;
        pslverr_nxt = take && !(hit_data || hit_ptr || hit_depth);
        prdata_nxt = 32'h0000_0000;
        if (take_data_rd) begin
            prdata_nxt = cap_en ? trp_pkg::READ_ERR_WORD : data_r; // [R1] [R3] [R12]
        end else if (take_ptr_rd) begin
            prdata_nxt = 32'(ptr_r) << trp_pkg::PTR_LSB; // [R7] [R11]
        end else if (take_depth_rd) begin
            prdata_nxt = trp_pkg::RAM_DEPTH_VAL; // [R13]
        end
    end

    // registered answer, pready is a one-cycle pulse
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // read pointer and fetch request
    // ------------------------------------------------------------
    always_comb begin
        ptr_nxt = ptr_r;
        pend_nxt = pend_r;
        if (take_data_rd && !cap_en) begin
            ptr_nxt = ptr_r + 10'h001; // [R2] [R15]
            pend_nxt = 1'b1; // [R2]
        end else if (take_ptr_wr && !cap_en) begin
            ptr_nxt = i_apb.wdata[trp_pkg::PTR_LSB +: trp_pkg::PTR_W]; // [R6] [R11]
            pend_nxt = 1'b1; // [R6]
        end else if (fetch_r == trp_pkg::FETCH_IDLE && pend_r && !cap_en) begin
            pend_nxt = 1'b0;
        end
        // ones-read and capture-time write leave the pointer alone [R4] [R10]
    end

    // ------------------------------------------------------------
    // fetch state machine
    // ------------------------------------------------------------
    always_comb begin
        fetch_nxt = fetch_r;
        data_nxt = data_r;
        case (fetch_r)
            trp_pkg::FETCH_IDLE: begin
                if (pend_r && !cap_en) begin
                    fetch_nxt = trp_pkg::FETCH_REQ;
                end
            end
            trp_pkg::FETCH_REQ: begin
                fetch_nxt = trp_pkg::FETCH_LOAD;
            end
            trp_pkg::FETCH_LOAD: begin
                data_nxt = ram_q; // [R1] [R6]
                fetch_nxt = trp_pkg::FETCH_IDLE;
            end
            default: begin
                fetch_nxt = trp_pkg::FETCH_IDLE;
            end
        endcase
    end

    // pointer and fetch registers, a fetch of word 0 follows reset
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fetch_r <= trp_pkg::FETCH_IDLE;
            ptr_r <= trp_pkg::PTR_RST;
            pend_r <= 1'b1;
            data_r <= trp_pkg::DATA_RST;
        end else begin
            fetch_r <= fetch_nxt;
            ptr_r <= ptr_nxt;
            pend_r <= pend_nxt;
            data_r <= data_nxt;
        end
    end

    // ------------------------------------------------------------
    // formatter stopped flag
    // ------------------------------------------------------------
    always_comb begin
        en_d_nxt = i_capture_enable_bit;
        stopped_nxt = stopped_r;
        if (!i_capture_enable_bit || i_fmt_stop_event) begin
            stopped_nxt = 1'b1; // [R14]
        end else if (!en_d_r) begin
            stopped_nxt = 1'b0; // new capture run
        end
    end

    // stopped flag and enable history
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stopped_r <= trp_pkg::STOPPED_RST;
            en_d_r <= 1'b0;
        end else begin
            stopped_r <= stopped_nxt;
            en_d_r <= en_d_nxt;
        end
    end

    // ------------------------------------------------------------
    // capture path: fifo into the single-port ram
    // ------------------------------------------------------------
    // fetch owns the ram port in its request cycle, stalling the drain
    assign ram_wr = fifo_valid && (fetch_r != trp_pkg::FETCH_REQ);

    trp_fifo #(
        .WIDTH($bits(trp_pkg::trp_cap_word_s)),
        .DEPTH(trp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_in_valid(i_cap_valid),
        .i_in_data(i_cap_word),
        .o_in_ready(o_cap_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_word),
        .i_out_ready(fetch_r != trp_pkg::FETCH_REQ)
    );

    trp_trace_ram u_ram (
        .i_core_clk(i_core_clk),
        .i_rd_en(fetch_r == trp_pkg::FETCH_REQ),
        .i_rd_addr(ptr_r),
        .o_rd_data(ram_q),
        .i_wr_en(ram_wr),
        .i_wr_addr(fifo_word.addr),
        .i_wr_data(fifo_word.data)
    );

    // outputs
    assign o_apb_prdata = prdata_r;
    assign o_apb_pready = pready_r;
    assign o_apb_pslverr = pslverr_r;
    assign o_formatter_stopped = stopped_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    a_ones_on_capture: assert property ( // [R3]
        take_data_rd && cap_en |=> o_apb_pready && o_apb_prdata == trp_pkg::READ_ERR_WORD)
        else $error("capture-time data read did not return all ones");

    a_ptr_hold_capture: assert property ( // [R4]
        take_data_rd && cap_en |=> $stable(ptr_r) ##1 $stable(ptr_r))
        else $error("pointer moved on all-ones read");

    a_ptr_increment: assert property ( // [R2]
        take_data_rd && !cap_en |=> ptr_r == $past(ptr_r) + 10'h001 && pend_r)
        else $error("pointer did not advance on data read");

    a_ptr_wrap_zero: assert property ( // [R15]
        take_data_rd && !cap_en && ptr_r == 10'h3FF |=> ptr_r == 10'h000)
        else $error("pointer did not wrap to zero");

    a_data_word_read: assert property ( // [R12]
        take_data_rd && !cap_en |=> o_apb_prdata == $past(data_r) && !o_apb_pslverr)
        else $error("data read returned wrong word");

    a_ptr_write_load: assert property ( // [R6]
        take_ptr_wr && !cap_en |=> ptr_r == $past(i_apb.wdata[9:0]) && pend_r)
        else $error("pointer write not loaded");

    a_ptr_write_lock: assert property ( // [R10]
        take_ptr_wr && cap_en |=> $stable(ptr_r) && !pend_r == !$past(pend_r))
        else $error("pointer changed during capture");

    a_fetch_sequence: assert property ( // [R16]
        fetch_r == trp_pkg::FETCH_IDLE && pend_r && !cap_en |=>
        fetch_r == trp_pkg::FETCH_REQ ##1 fetch_r == trp_pkg::FETCH_LOAD ##1 fetch_idle)
        else $error("fetch did not finish in three cycles");

    // ram is not reset, so the word fetched after reset may be unknown
    a_fetch_loads_ram: assert property ( // [R1]
        fetch_r == trp_pkg::FETCH_LOAD |=> data_r === $past(ram_q))
        else $error("read data not refreshed from ram");

    a_ptr_readback: assert property ( // [R7]
        take_ptr_rd |=> o_apb_prdata == {22'h000000, $past(ptr_r)} && $stable(ptr_r))
        else $error("pointer readback wrong");

    a_depth_value: assert property ( // [R13]
        take_depth_rd |=> o_apb_prdata == trp_pkg::RAM_DEPTH_VAL)
        else $error("depth register wrong");

    a_stop_release: assert property ( // [R14]
        !i_capture_enable_bit || i_fmt_stop_event |=> o_formatter_stopped)
        else $error("formatter not stopped after acquisition end");

    a_fetch_wait_state: assert property ( // [R16]
        acc && (hit_data || hit_ptr) && !cap_en && !fetch_idle |=> !o_apb_pready)
        else $error("register answered while a fetch was running");

    a_ptr_reserved_zero: assert property ( // [R11]
        take_ptr_rd |=> o_apb_prdata[31:10] == 22'h0)
        else $error("reserved pointer bits not zero");

    a_fetch_after_read: assert property ( // [R2]
        take_data_rd && !cap_en ##1 !cap_en |=> fetch_r == trp_pkg::FETCH_REQ)
        else $error("data read did not start a fetch");

    a_data_write_ignored: assert property ( // [R12]
        take && hit_data && i_apb.write |=> $stable(ptr_r) && !o_apb_pslverr)
        else $error("write to read-data register had an effect");

    a_run_start_clear: assert property ( // [R8]
        i_capture_enable_bit && !$past(i_capture_enable_bit) && !i_fmt_stop_event |=> !o_formatter_stopped)
        else $error("new capture run did not clear stopped flag");

    a_data_hold_capture: assert property ( // [R8]
        cap_en && fetch_r == trp_pkg::FETCH_IDLE |=> $stable(data_r))
        else $error("read data changed during capture");

    c_normal_read: cover property (take_data_rd && !cap_en ##1 o_apb_pready);
    c_ones_read: cover property (take_data_rd && cap_en);
    c_ptr_write: cover property (take_ptr_wr && !cap_en ##3 fetch_idle);
    c_fifo_full: cover property (i_cap_valid && !o_cap_ready);
    c_fetch_wait: cover property (acc && hit_ptr && !cap_en && !fetch_idle);

endmodule

`default_nettype wire

// ### dv/trp_apb_host.sv
/*
 * Debug host model: issues single register accesses on the APB-style request.
 * Assumes the readout port answers with a one-cycle pready pulse.
 */
`default_nettype none

module trp_apb_host (
    // clock
    input wire logic i_core_clk,
    // capture state seen by software
    input wire logic i_cap_on,
    // apb master side
    output var trp_pkg::trp_apb_req_s o_apb,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // one access: setup, access, hold until pready is sampled high
    // ------------------------------------------------------------
    initial o_apb = '0;

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, input bit brk,
                        output logic [31:0] rd, output logic err, output bit tmo);
        int n;
        rd = '0;
        err = 1'b0;
        tmo = 1'b0;
        n = 0;
        // no pointer write while capture runs, unless a test means to
        if (wr && a == trp_pkg::OFS_READ_PTR && i_cap_on && !brk) return;
        @(posedge i_core_clk);
        o_apb <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: wd};
        @(posedge i_core_clk);
        o_apb.enable <= 1'b1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (i_pready !== 1'b1 && n < 20);
        tmo = (i_pready !== 1'b1);
        rd = i_prdata;
        err = i_pslverr;
        o_apb <= '0;
    endtask

endmodule

`default_nettype wire

// ### dv/testbench.sv
/*
 * Self-checking bench of the trace RAM readout port.
 * Assumes the host model drives the register side and the bench the capture side.
 */
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic i_core_clk = 1'b0;
    logic i_arst_n = 1'b0;
    trp_pkg::trp_apb_req_s apb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic en_bit = 1'b0;
    logic stop_ev = 1'b0;
    logic stopped;
    logic cap_valid = 1'b0;
    trp_pkg::trp_cap_word_s cap_word = '0;
    logic cap_ready;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;

    // ------------------------------------------------------------
    // clock, instances, timeout
    // ------------------------------------------------------------
    initial forever #10 i_core_clk = ~i_core_clk;

    trp_readout trp_readout_inst (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_apb(apb), .o_apb_prdata(prdata),
        .o_apb_pready(pready), .o_apb_pslverr(pslverr), .i_capture_enable_bit(en_bit),
        .i_fmt_stop_event(stop_ev), .o_formatter_stopped(stopped), .i_cap_valid(cap_valid),
        .i_cap_word(cap_word), .o_cap_ready(cap_ready)
    );

    trp_apb_host trp_apb_host_inst (
        .i_core_clk(i_core_clk), .i_cap_on(!stopped && en_bit), .o_apb(apb),
        .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr)
    );

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            $display("[ERR] %0t run did not finish", $time);
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] pat(int i);
        return 32'hA5C3_0000 | 32'(i);
    endfunction

    function automatic logic [9:0] adr(int i);
        return (i == 7) ? 10'h3FF : 10'(i);
    endfunction

    // read one register and compare data and error flag
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] rd;
        logic err;
        bit tmo;
        trp_apb_host_inst.xfer(1'b0, a, '0, 1'b0, rd, err, tmo);
        `CHK(tmo, 1'b0)
        `CHK(rd, exp)
        `CHK(err, eexp)
    endtask

    // write one register
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input bit brk);
        logic [31:0] rd;
        logic err;
        bit tmo;
        trp_apb_host_inst.xfer(1'b1, a, d, brk, rd, err, tmo);
        `CHK(tmo, 1'b0)
    endtask

    // hand eight capture words over, valid held until ready is seen
    task automatic push_words();
        int n;
        @(posedge i_core_clk);
        for (int i = 0; i < 8; i++) begin
            cap_valid <= 1'b1;
            cap_word <= '{addr: adr(i), data: pat(i)};
            n = 0;
            do begin
                @(posedge i_core_clk);
                n++;
            end while (cap_ready !== 1'b1 && n < 50);
            `CHK(cap_ready, 1'b1)
        end
        cap_valid <= 1'b0;
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        // first access lands on the reset-time fetch and gets a wait state
        rdchk(trp_pkg::OFS_READ_PTR, 32'h0000_0000, 1'b0);
        `CHK(stopped, 1'b1)
        rdchk(trp_pkg::OFS_RAM_DEPTH, trp_pkg::RAM_DEPTH_VAL, 1'b0);
        // capture on: fill the RAM, reads give all ones, pointer locked
        en_bit <= 1'b1;
        push_words();
        `CHK(stopped, 1'b0)
        for (int i = 0; i < 3; i++) begin
            rdchk(trp_pkg::OFS_READ_DATA, trp_pkg::READ_ERR_WORD, 1'b0);
        end
        wr(trp_pkg::OFS_READ_PTR, 32'h0000_0155, 1'b1);
        rdchk(trp_pkg::OFS_READ_PTR, 32'h0000_0000, 1'b0);
        // capture off: stopped rises, data streams out with auto increment
        en_bit <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        `CHK(stopped, 1'b1)
        wr(trp_pkg::OFS_READ_PTR, 32'h0000_0000, 1'b0);
        for (int i = 0; i < 7; i++) begin
            rdchk(trp_pkg::OFS_READ_DATA, pat(i), 1'b0);
        end
        rdchk(trp_pkg::OFS_READ_PTR, 32'h0000_0007, 1'b0);
        rdchk(trp_pkg::OFS_READ_PTR, 32'h0000_0007, 1'b0);
        // reserved bits dropped, top entry, wrap to zero
        wr(trp_pkg::OFS_READ_PTR, 32'hFFFF_FFFF, 1'b0);
        rdchk(trp_pkg::OFS_READ_PTR, 32'h0000_03FF, 1'b0);
        rdchk(trp_pkg::OFS_READ_DATA, pat(7), 1'b0);
        rdchk(trp_pkg::OFS_READ_PTR, 32'h0000_0000, 1'b0);
        // read-only data register and unmapped place
        wr(trp_pkg::OFS_READ_DATA, 32'h0000_0123, 1'b0);
        rdchk(trp_pkg::OFS_READ_PTR, 32'h0000_0000, 1'b0);
        rdchk(12'h020, 32'h0000_0000, 1'b1);
        // stop event alone ends capture while enable stays set
        en_bit <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        `CHK(stopped, 1'b0)
        rdchk(trp_pkg::OFS_READ_DATA, trp_pkg::READ_ERR_WORD, 1'b0);
        stop_ev <= 1'b1;
        @(posedge i_core_clk);
        stop_ev <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        `CHK(stopped, 1'b1)
        rdchk(trp_pkg::OFS_READ_DATA, pat(0), 1'b0);
        rdchk(trp_pkg::OFS_READ_PTR, 32'h0000_0001, 1'b0);
        give_verdict();
    end

endmodule

`undef CHK

`default_nettype wire
